// ===== common/rtcca_defines.svh
// Offsets, field positions, reset values and timing counts of the calendar core.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef RTCCA_DEFINES_SVH
`define RTCCA_DEFINES_SVH

// Register byte offsets
`define RTCCA_ADDR_SEC      8'h02
`define RTCCA_ADDR_MIN      8'h03
`define RTCCA_ADDR_HOUR     8'h04
`define RTCCA_ADDR_DAY      8'h05
`define RTCCA_ADDR_WDAY     8'h06
`define RTCCA_ADDR_MON      8'h07
`define RTCCA_ADDR_YEAR     8'h08
`define RTCCA_ADDR_AMIN     8'h09
`define RTCCA_ADDR_AHOUR    8'h0a
`define RTCCA_ADDR_ADAY     8'h0b
`define RTCCA_ADDR_AWDAY    8'h0c

// Field positions
`define RTCCA_FLAG_BIT      7
`define RTCCA_SEC_MSB       6
`define RTCCA_HOUR_MSB      5
`define RTCCA_MON_MSB       4
`define RTCCA_WDAY_MSB      2

// BCD limits
`define RTCCA_SEC_MAX       8'h59
`define RTCCA_MIN_MAX       8'h59
`define RTCCA_HOUR_MAX      8'h23
`define RTCCA_MON_MAX       8'h12
`define RTCCA_YEAR_MAX      8'h99
`define RTCCA_WDAY_MAX      8'h06
`define RTCCA_DAY_FIRST     8'h01
`define RTCCA_MON_FIRST     8'h01

// Reset values
`define RTCCA_RST_TIME      8'h00
`define RTCCA_RST_DATE      8'h01
`define RTCCA_RST_FLAG      1'b1
`define RTCCA_RST_ALARM     8'h80

// Timing
`define RTCCA_CLK_PERIOD_NS 10
`define RTCCA_TICK_PERIOD_NS 1000000000
`define RTCCA_TICK_CYCLES   (`RTCCA_TICK_PERIOD_NS / `RTCCA_CLK_PERIOD_NS)

`endif

// ===== common/rtcca_pkg.sv
// Types shared by the calendar core and its bench.
// Assumes nothing of its surroundings.
package rtcca_pkg;

  typedef logic [7:0]  rtcca_byte_t;
  typedef logic [31:0] rtcca_count_t;

endpackage : rtcca_pkg

// ===== design/rtcca_core.sv
// Timekeeping, calendar and alarm compare core with a byte register port.
// Assumes a control block that drives stop, flag clear and irq enable on sys_clk_in,
// and an asynchronous supply fail level from a power detector.
//
// Overview of operation
// - Seconds count kept in BCD in bits 6..0, advancing each second tick.
// - Seconds bit 7 is the integrity flag; 1 means time may be wrong.
// - Minutes BCD 00..59 in bits 6..0; bit 7 unused.
// - Hours BCD 00..23 in bits 5..0; bits 7..6 unused.
// - Day of month BCD 01..31 in bits 5..0; bits 7..6 unused.
// - February runs to day 29 in a leap year.
// - Weekday 0..6 in bits 2..0, cyclic; bits 7..3 unused.
// - Month bit 7 is century: 0 means 20xx, 1 means 19xx.
// - Year wrap from 99 to 00 inverts the century bit.
// - Month BCD 01..12 in bits 4..0; bits 6..5 unused.
// - Year BCD 00..99 across all eight bits.
// - Alarm flag set when at least one alarm field is enabled and all enabled fields equal current time.
// - Alarm flag stays set until software clears it.
// - After clearing, flag sets again only on a later new match.
// - Alarm fields with disable bit 1 are left out of the compare.
// - Minute alarm: disable in bit 7, BCD minute in bits 6..0.
// - Hour alarm: disable in bit 7, BCD hour in bits 5..0.
// - Day alarm: disable in bit 7, BCD day in bits 5..0.
// - Weekday alarm: disable in bit 7, weekday in bits 2..0.
// - Stop control holds the divider at zero; no counter advances.
// - Alarm sets the flag; with irq enable the interrupt goes active.
`include "rtcca_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module rtcca_core #(
  parameter int unsigned TICK_CYCLES = `RTCCA_TICK_CYCLES
) (
  input  wire logic                sys_clk_in,
  input  wire logic                sys_rst_in,
  input  wire rtcca_pkg::rtcca_byte_t reg_addr_in,
  input  wire logic                reg_wr_in,
  input  wire rtcca_pkg::rtcca_byte_t reg_wdata_in,
  input  wire logic                reg_rd_in,
  input  wire logic                stop_in,
  input  wire logic                alarm_flag_clear_in,
  input  wire logic                alarm_irq_enable_in,
  input  wire logic                supply_fail_in,
  output logic                     reg_rvalid_out,
  output rtcca_pkg::rtcca_byte_t   reg_rdata_out,
  output logic                     alarm_match_flag_out,
  output logic                     alarm_irq_n_out
);
  import rtcca_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic rtcca_byte_t bcd_inc(input rtcca_byte_t v, input rtcca_byte_t lim,
                                          input rtcca_byte_t lo);
    if (v >= lim) begin
      bcd_inc = lo;
    end else if (v[3:0] >= 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = v + 8'h01;
    end
  endfunction : bcd_inc

  // Tens parity picks which units digits make the binary year divisible by four
  function automatic logic is_leap(input rtcca_byte_t y);
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction : is_leap

  function automatic rtcca_byte_t month_last(input logic [4:0] m, input logic leap);
    case (m)
      5'h02: month_last = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: month_last = 8'h30;
      default: month_last = 8'h31;
    endcase
  endfunction : month_last

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [6:0]   sec, min;
  logic [5:0]   hour, day;
  logic [4:0]   mon;
  logic [2:0]   wday;
  logic         integrity_flag, century;
  rtcca_byte_t  year;
  rtcca_byte_t  alarm_min, alarm_hour, alarm_day, alarm_wday;
  rtcca_count_t div_cnt;
  logic         tick, tick_q;
  logic         match_prev, alarm_flag;
  logic [2:0]   fail_sync;
  logic         fail_level;
  logic         c_sec, c_min, c_hour, c_day, c_mon, c_year;
  rtcca_byte_t  day_last;
  rtcca_byte_t  next_sec, next_min, next_hour, next_day, next_wday, next_mon, next_year;
  logic         match_now, new_match, next_alarm_flag;
  rtcca_byte_t  next_rdata;
  logic         wr_sec, wr_min, wr_hour, wr_day, wr_wday, wr_mon, wr_year;
  assign wr_sec  = reg_wr_in && (reg_addr_in == `RTCCA_ADDR_SEC);
  assign wr_min  = reg_wr_in && (reg_addr_in == `RTCCA_ADDR_MIN);
  assign wr_hour = reg_wr_in && (reg_addr_in == `RTCCA_ADDR_HOUR);
  assign wr_day  = reg_wr_in && (reg_addr_in == `RTCCA_ADDR_DAY);
  assign wr_wday = reg_wr_in && (reg_addr_in == `RTCCA_ADDR_WDAY);
  assign wr_mon  = reg_wr_in && (reg_addr_in == `RTCCA_ADDR_MON);
  assign wr_year = reg_wr_in && (reg_addr_in == `RTCCA_ADDR_YEAR);
  ////////////////////////////////////////////////////////////////////////////
  // Second divider

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || stop_in) begin
      div_cnt <= '0;
    end else if (div_cnt >= TICK_CYCLES - 32'd1) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 32'd1;
    end
  end
  assign tick = !stop_in && (div_cnt >= TICK_CYCLES - 32'd1);
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Carry chain

  always_comb begin
    day_last  = month_last(mon, is_leap(year));
    c_sec     = tick && ({1'b0, sec} >= `RTCCA_SEC_MAX);
    c_min     = c_sec && ({1'b0, min} >= `RTCCA_MIN_MAX);
    c_hour    = c_min && ({2'b00, hour} >= `RTCCA_HOUR_MAX);
    c_day     = c_hour && ({2'b00, day} >= day_last);
    c_mon     = c_day && ({3'b000, mon} >= `RTCCA_MON_MAX);
    c_year    = c_mon && (year >= `RTCCA_YEAR_MAX);
    next_sec  = bcd_inc({1'b0, sec}, `RTCCA_SEC_MAX, `RTCCA_RST_TIME);
    next_min  = bcd_inc({1'b0, min}, `RTCCA_MIN_MAX, `RTCCA_RST_TIME);
    next_hour = bcd_inc({2'b00, hour}, `RTCCA_HOUR_MAX, `RTCCA_RST_TIME);
    next_day  = bcd_inc({2'b00, day}, day_last, `RTCCA_DAY_FIRST);
    next_wday = bcd_inc({5'b00000, wday}, `RTCCA_WDAY_MAX, `RTCCA_RST_TIME);
    next_mon  = bcd_inc({3'b000, mon}, `RTCCA_MON_MAX, `RTCCA_MON_FIRST);
    next_year = bcd_inc(year, `RTCCA_YEAR_MAX, `RTCCA_RST_TIME);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time counters; a host write to a field wins over its own count

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sec <= 7'(`RTCCA_RST_TIME);
    end else if (wr_sec) begin
      sec <= reg_wdata_in[`RTCCA_SEC_MSB:0];
    end else if (tick) begin
      sec <= next_sec[`RTCCA_SEC_MSB:0];
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      min <= 7'(`RTCCA_RST_TIME);
    end else if (wr_min) begin
      min <= reg_wdata_in[`RTCCA_SEC_MSB:0];
    end else if (c_sec) begin
      min <= next_min[`RTCCA_SEC_MSB:0];
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      hour <= 6'(`RTCCA_RST_TIME);
    end else if (wr_hour) begin
      hour <= reg_wdata_in[`RTCCA_HOUR_MSB:0];
    end else if (c_min) begin
      hour <= next_hour[`RTCCA_HOUR_MSB:0];
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      day <= 6'(`RTCCA_RST_DATE);
    end else if (wr_day) begin
      day <= reg_wdata_in[`RTCCA_HOUR_MSB:0];
    end else if (c_hour) begin
      day <= next_day[`RTCCA_HOUR_MSB:0];
    end
  end
  // Weekday only cycles; no tie to the date, so the host owns its meaning
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      wday <= 3'(`RTCCA_RST_TIME);
    end else if (wr_wday) begin
      wday <= reg_wdata_in[`RTCCA_WDAY_MSB:0];
    end else if (c_hour) begin
      wday <= next_wday[`RTCCA_WDAY_MSB:0];
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      mon <= 5'(`RTCCA_RST_DATE);
    end else if (wr_mon) begin
      mon <= reg_wdata_in[`RTCCA_MON_MSB:0];
    end else if (c_day) begin
      mon <= next_mon[`RTCCA_MON_MSB:0];
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      century <= 1'b0;
    end else if (wr_mon) begin
      century <= reg_wdata_in[`RTCCA_FLAG_BIT];
    end else if (c_year) begin
      century <= !century;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      year <= `RTCCA_RST_TIME;
    end else if (wr_year) begin
      year <= reg_wdata_in;
    end else if (c_mon) begin
      year <= next_year;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Integrity flag; supply fail wins over a host clear in the same cycle

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      fail_sync <= 3'h0;
    end else begin
      fail_sync <= {fail_sync[1:0], supply_fail_in};
    end
  end
  assign fail_level = fail_sync[1] && fail_sync[2];
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      integrity_flag <= `RTCCA_RST_FLAG;
    end else if (fail_level) begin
      integrity_flag <= 1'b1;
    end else if (wr_sec) begin
      integrity_flag <= reg_wdata_in[`RTCCA_FLAG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm registers; unused bits are dropped on write

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      alarm_min  <= `RTCCA_RST_ALARM;
      alarm_hour <= `RTCCA_RST_ALARM;
      alarm_day  <= `RTCCA_RST_ALARM;
      alarm_wday <= `RTCCA_RST_ALARM;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `RTCCA_ADDR_AMIN:  alarm_min  <= reg_wdata_in & 8'hff;
        `RTCCA_ADDR_AHOUR: alarm_hour <= reg_wdata_in & 8'hbf;
        `RTCCA_ADDR_ADAY:  alarm_day  <= reg_wdata_in & 8'hbf;
        `RTCCA_ADDR_AWDAY: alarm_wday <= reg_wdata_in & 8'h87;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm compare, judged one cycle after each tick on the updated time

  always_comb begin
    match_now = (alarm_min[`RTCCA_FLAG_BIT]  || (alarm_min[6:0] == min))
             && (alarm_hour[`RTCCA_FLAG_BIT] || (alarm_hour[5:0] == hour))
             && (alarm_day[`RTCCA_FLAG_BIT]  || (alarm_day[5:0] == day))
             && (alarm_wday[`RTCCA_FLAG_BIT] || (alarm_wday[2:0] == wday))
             && !(alarm_min[7] && alarm_hour[7] && alarm_day[7] && alarm_wday[7]);
    new_match = tick_q && match_now && !match_prev;
    if (new_match) begin
      next_alarm_flag = 1'b1;
    end else if (alarm_flag_clear_in) begin
      next_alarm_flag = 1'b0;
    end else begin
      next_alarm_flag = alarm_flag;
    end
  end

  // Every cycle, so host writes before a tick count as the pre-increment state
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      match_prev <= 1'b0;
    end else begin
      match_prev <= match_now;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      alarm_flag <= 1'b0;
    end else begin
      alarm_flag <= next_alarm_flag;
    end
  end
  // Active low to suit an open-drain pin driver outside
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      alarm_irq_n_out <= 1'b1;
    end else begin
      alarm_irq_n_out <= !(alarm_flag && alarm_irq_enable_in);
    end
  end
  assign alarm_match_flag_out = alarm_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  always_comb begin
    case (reg_addr_in)
      `RTCCA_ADDR_SEC:   next_rdata = {integrity_flag, sec};
      `RTCCA_ADDR_MIN:   next_rdata = {1'b0, min};
      `RTCCA_ADDR_HOUR:  next_rdata = {2'b00, hour};
      `RTCCA_ADDR_DAY:   next_rdata = {2'b00, day};
      `RTCCA_ADDR_WDAY:  next_rdata = {5'b00000, wday};
      `RTCCA_ADDR_MON:   next_rdata = {century, 2'b00, mon};
      `RTCCA_ADDR_YEAR:  next_rdata = year;
      `RTCCA_ADDR_AMIN:  next_rdata = alarm_min;
      `RTCCA_ADDR_AHOUR: next_rdata = alarm_hour;
      `RTCCA_ADDR_ADAY:  next_rdata = alarm_day;
      `RTCCA_ADDR_AWDAY: next_rdata = alarm_wday;
      default:           next_rdata = 8'h00;
    endcase
  end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      reg_rvalid_out <= 1'b0;
      reg_rdata_out  <= 8'h00;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sec_advance_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    tick && !wr_sec && (sec[3:0] < 4'h9) && ({1'b0, sec} < `RTCCA_SEC_MAX)
      |=> sec == $past(sec) + 7'h01)
    else $error("seconds did not advance on tick");
  sec_wrap_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    tick && !wr_sec && !wr_min && ({1'b0, sec} == `RTCCA_SEC_MAX) && (min[3:0] < 4'h9)
      && ({1'b0, min} < `RTCCA_MIN_MAX) |=> (sec == 7'h00) && (min == $past(min) + 7'h01))
    else $error("seconds wrap did not carry into minutes");
  leap_feb_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    c_hour && !wr_day && !wr_mon && (mon == 5'h02) && (day == 6'h28) && is_leap(year)
      |=> (day == 6'h29) && (mon == 5'h02))
    else $error("leap February did not reach day 29");
  century_flip_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    c_year && !wr_mon && !wr_year |=> (century != $past(century)) && (year == 8'h00))
    else $error("century bit not inverted on year wrap");
  stop_hold_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    stop_in ##1 stop_in |-> (div_cnt == '0) && !tick)
    else $error("divider not held at zero while stopped");
  flag_set_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    new_match |=> alarm_flag)
    else $error("alarm flag not set on new match");
  flag_sticky_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    alarm_flag && !alarm_flag_clear_in |=> alarm_flag)
    else $error("alarm flag dropped without a clear");
  flag_rise_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !alarm_flag ##1 alarm_flag |-> $past(tick_q) && $past(match_now) && !$past(match_prev))
    else $error("alarm flag set without a new match after a tick");
  irq_drive_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    alarm_flag && alarm_irq_enable_in |=> !alarm_irq_n_out)
    else $error("interrupt not active with flag and enable");
  unused_zero_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    reg_rd_in && (reg_addr_in == `RTCCA_ADDR_HOUR) |=> reg_rvalid_out
      && (reg_rdata_out[7:6] == 2'b00))
    else $error("unused hour bits read nonzero");
  integrity_set_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    fail_level |=> integrity_flag)
    else $error("integrity flag not set on supply fail");

  cover_alarm_c: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    new_match ##1 alarm_flag);
  cover_year_c: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    c_year);
  cover_clear_c: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    alarm_flag ##1 alarm_flag_clear_in ##1 !alarm_flag);
  cover_stop_c: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    stop_in ##1 !stop_in);

endmodule : rtcca_core

`default_nettype wire

// ===== dv/rtcca_host_model.sv
// Host side of the calendar core: a byte register port master.
// Assumes the core takes strobes at the rising edge and answers a read one cycle later.
`timescale 1ns/1ps
`default_nettype none
module rtcca_host_model (
  input  wire logic                   sys_clk_in,
  input  wire logic                   reg_rvalid_in,
  input  wire rtcca_pkg::rtcca_byte_t reg_rdata_in,
  output var logic                    reg_wr_out,
  output var logic                    reg_rd_out,
  output rtcca_pkg::rtcca_byte_t      reg_addr_out,
  output rtcca_pkg::rtcca_byte_t      reg_wdata_out
);
  import rtcca_pkg::*;
  initial begin
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    reg_addr_out  = 8'h00;
    reg_wdata_out = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////
  // Idle address and data are inverted so stale values never match
  task automatic wr_reg(input rtcca_byte_t a, input rtcca_byte_t d);
    @(posedge sys_clk_in);
    #1;
    reg_wr_out    = 1'b1;
    reg_addr_out  = a;
    reg_wdata_out = d;
    @(posedge sys_clk_in);
    #1;
    reg_wr_out    = 1'b0;
    reg_addr_out  = ~a;
    reg_wdata_out = ~d;
  endtask : wr_reg
  task automatic rd_reg(input rtcca_byte_t a, output rtcca_byte_t d);
    d = 8'hxx;
    @(posedge sys_clk_in);
    #1;
    reg_rd_out   = 1'b1;
    reg_addr_out = a;
    @(posedge sys_clk_in);
    #1;
    reg_rd_out   = 1'b0;
    reg_addr_out = ~a;
    for (int n = 0; n < 4; n++) begin
      if (reg_rvalid_in === 1'b1) begin
        d = reg_rdata_in;
        break;
      end
      @(posedge sys_clk_in);
      #1;
    end
  endtask : rd_reg
endmodule : rtcca_host_model
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the calendar core: time, calendar and alarm.
// Assumes a shortened second tick of TICK clock cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rtcca_pkg::*;
  localparam int TICK = 20;
  logic        sys_clk_in, sys_rst_in, stop, clr, irq_en, fail;
  logic        wr, rd, rvalid, flag, irq_n;
  rtcca_byte_t addr, wdata, rdata, v;
  int          fails, checks, cyc;
  rtcca_byte_t lday[3] = '{8'h28, 8'h29, 8'h28};
  rtcca_byte_t lyr[3]  = '{8'h24, 8'h24, 8'h23};
  rtcca_byte_t eday[3] = '{8'h29, 8'h01, 8'h01};
  rtcca_byte_t emon[3] = '{8'h02, 8'h03, 8'h03};
  rtcca_core #(.TICK_CYCLES(TICK)) uut (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .stop_in(stop),
    .alarm_flag_clear_in(clr), .alarm_irq_enable_in(irq_en),
    .supply_fail_in(fail), .reg_rvalid_out(rvalid), .reg_rdata_out(rdata),
    .alarm_match_flag_out(flag), .alarm_irq_n_out(irq_n));
  rtcca_host_model host (
    .sys_clk_in(sys_clk_in), .reg_rvalid_in(rvalid), .reg_rdata_in(rdata),
    .reg_wr_out(wr), .reg_rd_out(rd), .reg_addr_out(addr), .reg_wdata_out(wdata));
  ////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic chk(input rtcca_byte_t got, input rtcca_byte_t exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_chk(input rtcca_byte_t a, input rtcca_byte_t exp);
    host.rd_reg(a, v);
    chk(v, exp);
  endtask : rd_chk
  task automatic load(input rtcca_byte_t t[7]);
    for (int i = 0; i < 7; i++) host.wr_reg(8'h02 + 8'(i), t[i]);
  endtask : load
  task automatic chk_time(input rtcca_byte_t t[7]);
    for (int i = 0; i < 7; i++) rd_chk(8'h02 + 8'(i), t[i]);
  endtask : chk_time
  // Releases the divider for exactly n ticks, then stops it again
  task automatic run_ticks(input int n);
    @(posedge sys_clk_in);
    #1 stop = 1'b0;
    repeat (n * TICK + 2) @(posedge sys_clk_in);
    #1 stop = 1'b1;
    repeat (3) @(posedge sys_clk_in);
    #1;
  endtask : run_ticks
  task automatic chk_pins(input logic f, input logic n);
    chk({7'h00, flag}, {7'h00, f});
    chk({7'h00, irq_n}, {7'h00, n});
  endtask : chk_pins
  // Minute goes 14 to 15 on the tick; weekday alarm byte under test
  task automatic alarm_try(input rtcca_byte_t wk, input logic f, input logic n);
    host.wr_reg(8'h0c, wk);
    host.wr_reg(8'h02, 8'h59);
    host.wr_reg(8'h03, 8'h14);
    run_ticks(1);
    chk_pins(f, n);
  endtask : alarm_try
  task automatic clear_flag;
    @(posedge sys_clk_in);
    #1 clr = 1'b1;
    @(posedge sys_clk_in);
    #1 clr = 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1;
  endtask : clear_flag
  ////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    {fails, checks, cyc} = '0;
    {stop, clr, irq_en, fail} = 4'b1000;
    sys_rst_in = 1'b1;
    repeat (10) @(posedge sys_clk_in);
    #1 sys_rst_in = 1'b0;
    chk_time('{8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00});
    rd_chk(8'h09, 8'h80);
    rd_chk(8'h00, 8'h00);
    load('{8'h59, 8'hd9, 8'he3, 8'hf1, 8'hfe, 8'h72, 8'h99});
    chk_time('{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h99});
    run_ticks(1);
    chk_time('{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h81, 8'h00});
    repeat (3 * TICK) @(posedge sys_clk_in);
    rd_chk(8'h02, 8'h00);
    for (int i = 0; i < 3; i++) begin
      load('{8'h59, 8'h59, 8'h23, lday[i], 8'h02, 8'h02, lyr[i]});
      run_ticks(1);
      rd_chk(8'h05, eday[i]);
      rd_chk(8'h07, emon[i]);
    end
    load('{8'h59, 8'h14, 8'h07, 8'h10, 8'h02, 8'h05, 8'h25});
    host.wr_reg(8'h09, 8'h15);
    host.wr_reg(8'h0a, 8'hc8);
    rd_chk(8'h0a, 8'h88);
    host.wr_reg(8'h0b, 8'h10);
    irq_en = 1'b1;
    chk_pins(1'b0, 1'b1);
    alarm_try(8'h03, 1'b0, 1'b1);
    alarm_try(8'h02, 1'b1, 1'b0);
    run_ticks(2);
    chk_pins(1'b1, 1'b0);
    clear_flag();
    chk_pins(1'b0, 1'b1);
    run_ticks(2);
    chk_pins(1'b0, 1'b1);
    irq_en = 1'b0;
    alarm_try(8'hfa, 1'b1, 1'b1);
    rd_chk(8'h0c, 8'h82);
    fail = 1'b1;
    repeat (5) @(posedge sys_clk_in);
    #1 fail = 1'b0;
    rd_chk(8'h02, 8'h80);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
